// *** hw/fault_alarm_pkg.sv ***
// Package: fault source indices, masks, register offsets and indicator codes for the fault alarm aggregator
//
// Overview of operation
// - Faults split into common and downconverter classes
// - Every source except external mute raises alarm
// - Summary alarm raises redundancy change-over request
// - External mute never raises the summary alarm
// - Every source reported and forces indicator red
// - Indicator green none, amber standby, red fault
// - Common faults mute output and raise alarm
// - Listed downconverter faults alarm without muting
// - LO and SHF faults mute and alarm
// - External mute mutes; mute independent of alarm
// - Thermal sensor drives over-temperature fault source
// - Both fault relays switch together from alarm
// - Relays normal when healthy, changed over on alarm
package fault_alarm_pkg;

  localparam int NUM_COMMON = 9;
  localparam int NUM_DEVICE = 10;
  localparam int NUM_FAULTS = NUM_COMMON + NUM_DEVICE;

  // Common unit fault bit positions
  localparam int F_PSU_5V     = 0;
  localparam int F_PSU_P15V   = 1;
  localparam int F_PSU_N15V   = 2;
  localparam int F_PSU_P36V   = 3;
  localparam int F_TEMP       = 4;
  localparam int F_HUMIDITY   = 5;
  localparam int F_GENERAL    = 6;
  localparam int F_REF_100M   = 7;
  localparam int F_COAX_SW    = 8;
  // Downconverter fault bit positions
  localparam int F_BLOCK      = 9;
  localparam int F_PSU_P3V    = 10;
  localparam int F_DC_FEED    = 11;
  localparam int F_PSU_P5V    = 12;
  localparam int F_LO1        = 13;
  localparam int F_LO2        = 14;
  localparam int F_INT_BLOCK  = 15;
  localparam int F_EXT_FAULT  = 16;
  localparam int F_INT_SHF    = 17;
  localparam int F_EXT_MUTE   = 18;

  // Per source: does it mute, does it raise the summary alarm
  // Common faults, both LOs, internal SHF and external mute; not external fault
  localparam logic [NUM_FAULTS-1:0] MUTE_MASK  = 19'h661FF;
  localparam logic [NUM_FAULTS-1:0] ALARM_MASK = 19'h3FFFF;
  localparam logic [NUM_FAULTS-1:0] COMMON_MASK = 19'h001FF;

  // Register map (word addresses on the plain port)
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_FAULT_NOW  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SUMMARY    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_EVT_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_EVT_ENABLE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_EVT_CLEAR  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CONTROL    = 4'h5;
  localparam logic [ADDR_W-1:0] REG_FORCE      = 4'h6;

  // Control register bits
  localparam int CTRL_REDUNDANT = 0;
  localparam int CTRL_STANDBY   = 1;
  localparam int CTRL_W         = 2;

  // Event status bits: fault rise per source, then alarm rise, mute rise
  localparam int EVT_ALARM = NUM_FAULTS;
  localparam int EVT_MUTE  = NUM_FAULTS + 1;
  localparam int EVT_W     = NUM_FAULTS + 2;

  localparam logic [NUM_FAULTS-1:0] FAULT_RESET = '0;
  localparam logic [EVT_W-1:0]      EVT_RESET   = '0;
  localparam logic [CTRL_W-1:0]     CTRL_RESET  = 2'h0;

  typedef enum logic [1:0] {
    LED_OFF,
    LED_GREEN,
    LED_AMBER,
    LED_RED
  } led_type;

endpackage : fault_alarm_pkg

// *** hw/fault_input_sync.sv ***
// Three-stage synchroniser with agreement filter for a vector of fault pins
`timescale 1ns/1ps
module fault_input_sync
  import fault_alarm_pkg::*;
#(
  parameter int WIDTH = NUM_FAULTS
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // A bit changes only when the second and third stages agree
  always_comb begin
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  // Stage one feeds only stage two, keeping metastability contained
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= next_level;
    end
  end

  assign level_out = level;

endmodule : fault_input_sync

// *** hw/fault_alarm_aggregator.sv ***
// Top module: collects fault sources and drives alarm, mute, relays, indicator and interrupt
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module fault_alarm_aggregator
  import fault_alarm_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Common unit fault detectors
  input  wire logic                  psu_5v_fault,
  input  wire logic                  psu_p15v_fault,
  input  wire logic                  psu_n15v_fault,
  input  wire logic                  psu_p36v_fault,
  input  wire logic                  thermal_sensor_alarm,
  input  wire logic                  humidity_fault,
  input  wire logic                  general_fault,
  input  wire logic                  ref_100m_fault,
  input  wire logic                  coax_switch_fault,
  // Downconverter fault detectors and external inputs
  input  wire logic                  block_fault,
  input  wire logic                  psu_p3v_fault,
  input  wire logic                  dc_feed_fault,
  input  wire logic                  psu_p5v_fault,
  input  wire logic                  lo1_fault,
  input  wire logic                  lo2_fault,
  input  wire logic                  int_block_fault,
  input  wire logic                  ext_fault,
  input  wire logic                  int_shf_fault,
  input  wire logic                  ext_mute,
  // Register port
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // Results
  output logic                       summary_alarm,
  output logic                       changeover_req,
  output logic                       output_mute,
  output logic                       relay_a_drive,
  output logic                       relay_b_drive,
  output led_type                    status_led,
  output logic      [NUM_FAULTS-1:0] fault_report,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Input capture

  logic [NUM_FAULTS-1:0] raw_faults;
  logic [NUM_FAULTS-1:0] sync_faults;

  // Pack pins by class: common first, then downconverter
  always_comb begin
    raw_faults              = '0;
    raw_faults[F_PSU_5V]    = psu_5v_fault;
    raw_faults[F_PSU_P15V]  = psu_p15v_fault;
    raw_faults[F_PSU_N15V]  = psu_n15v_fault;
    raw_faults[F_PSU_P36V]  = psu_p36v_fault;
    raw_faults[F_TEMP]      = thermal_sensor_alarm;
    raw_faults[F_HUMIDITY]  = humidity_fault;
    raw_faults[F_GENERAL]   = general_fault;
    raw_faults[F_REF_100M]  = ref_100m_fault;
    raw_faults[F_COAX_SW]   = coax_switch_fault;
    raw_faults[F_BLOCK]     = block_fault;
    raw_faults[F_PSU_P3V]   = psu_p3v_fault;
    raw_faults[F_DC_FEED]   = dc_feed_fault;
    raw_faults[F_PSU_P5V]   = psu_p5v_fault;
    raw_faults[F_LO1]       = lo1_fault;
    raw_faults[F_LO2]       = lo2_fault;
    raw_faults[F_INT_BLOCK] = int_block_fault;
    raw_faults[F_EXT_FAULT] = ext_fault;
    raw_faults[F_INT_SHF]   = int_shf_fault;
    raw_faults[F_EXT_MUTE]  = ext_mute;
  end

  // Pins come from outside the clock domain
  fault_input_sync #(
    .WIDTH (NUM_FAULTS)
  ) u_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    (raw_faults),
    .level_out (sync_faults)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [CTRL_W-1:0]     control;
  logic [CTRL_W-1:0]     next_control;
  logic [NUM_FAULTS-1:0] force_faults;
  logic [NUM_FAULTS-1:0] next_force_faults;
  logic [EVT_W-1:0]      evt_status;
  logic [EVT_W-1:0]      next_evt_status;
  logic [EVT_W-1:0]      evt_enable;
  logic [EVT_W-1:0]      next_evt_enable;
  logic [31:0]           next_reg_rdata;

  // Outputs and the previous-state copies used for edge events
  logic [NUM_FAULTS-1:0] active;
  logic                  next_summary_alarm;
  logic                  next_changeover_req;
  logic                  next_output_mute;
  led_type               next_status_led;
  logic                  next_irq;
  logic [NUM_FAULTS-1:0] prev_faults;
  logic                  prev_alarm;
  logic                  prev_mute;
  logic [EVT_W-1:0]      evt_rise;

  // Software may inject faults for test; they merge with the real ones
  assign active = sync_faults | force_faults;

  // Reduction helpers shared by the outputs
  function automatic logic any_masked(input logic [NUM_FAULTS-1:0] f, input logic [NUM_FAULTS-1:0] m);
    any_masked = |(f & m);
  endfunction : any_masked

  function automatic logic [31:0] widen_evt(input logic [EVT_W-1:0] v);
    widen_evt = {{(32-EVT_W){1'b0}}, v};
  endfunction : widen_evt

  // Rising edges of each source, of the alarm and of the mute
  always_comb begin
    evt_rise                      = '0;
    evt_rise[NUM_FAULTS-1:0]      = active & ~prev_faults;
    evt_rise[EVT_ALARM]           = summary_alarm & ~prev_alarm;
    evt_rise[EVT_MUTE]            = output_mute & ~prev_mute;
  end

  // Register writes, sticky events and read mux
  always_comb begin
    next_control      = control;
    next_force_faults = force_faults;
    next_evt_enable   = evt_enable;
    next_evt_status   = evt_status;
    next_reg_rdata    = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CONTROL:    next_control      = reg_wdata[CTRL_W-1:0];
        REG_FORCE:      next_force_faults = reg_wdata[NUM_FAULTS-1:0];
        REG_EVT_ENABLE: next_evt_enable   = reg_wdata[EVT_W-1:0];
        REG_EVT_CLEAR:  next_evt_status   = evt_status & ~reg_wdata[EVT_W-1:0];
        default:        next_control      = control;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_evt_status = next_evt_status | evt_rise;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_FAULT_NOW:  next_reg_rdata = {{(32-NUM_FAULTS){1'b0}}, active};
        REG_SUMMARY:    next_reg_rdata = {{(32-4){1'b0}}, summary_alarm, output_mute, status_led};
        REG_EVT_STATUS: next_reg_rdata = widen_evt(evt_status);
        REG_EVT_ENABLE: next_reg_rdata = widen_evt(evt_enable);
        REG_CONTROL:    next_reg_rdata = {{(32-CTRL_W){1'b0}}, control};
        REG_FORCE:      next_reg_rdata = {{(32-NUM_FAULTS){1'b0}}, force_faults};
        default:        next_reg_rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm, mute and indicator

  // Recomputed each cycle from the registered flags
  always_comb begin
    // External mute sits outside ALARM_MASK, so it never alarms
    next_summary_alarm  = any_masked(active, ALARM_MASK);
    // Mute ignores the alarm mask entirely
    next_output_mute    = any_masked(active, MUTE_MASK);
    // Change-over only matters when paired with a standby unit
    next_changeover_req = next_summary_alarm & control[CTRL_REDUNDANT];
    // Any source, mute included, forces red ahead of standby amber
    if (|active) begin
      next_status_led = LED_RED;
    end else if (control[CTRL_STANDBY]) begin
      next_status_led = LED_AMBER;
    end else begin
      next_status_led = LED_GREEN;
    end
    // Next enable too, so the line follows a mask write with no extra cycle
    next_irq = |(next_evt_status & next_evt_enable);
  end

  // Register port state and edge-detect copies, registered only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      control      <= CTRL_RESET;
      force_faults <= FAULT_RESET;
      evt_enable   <= EVT_RESET;
      evt_status   <= EVT_RESET;
      reg_rdata    <= '0;
      prev_faults  <= FAULT_RESET;
      prev_alarm   <= 1'b0;
      prev_mute    <= 1'b0;
    end else begin
      control      <= next_control;
      force_faults <= next_force_faults;
      evt_enable   <= next_evt_enable;
      evt_status   <= next_evt_status;
      reg_rdata    <= next_reg_rdata;
      // Copies lag by one cycle so each rise is flagged exactly once
      prev_faults  <= active;
      prev_alarm   <= summary_alarm;
      prev_mute    <= output_mute;
    end
  end

  // Result outputs; each one leaves the block from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      summary_alarm  <= 1'b0;
      changeover_req <= 1'b0;
      output_mute    <= 1'b0;
      relay_a_drive  <= 1'b0;
      relay_b_drive  <= 1'b0;
      status_led     <= LED_OFF;
      fault_report   <= FAULT_RESET;
      irq            <= 1'b0;
    end else begin
      summary_alarm  <= next_summary_alarm;
      changeover_req <= next_changeover_req;
      output_mute    <= next_output_mute;
      // Both relays from the one alarm; low keeps contacts normal
      relay_a_drive  <= next_summary_alarm;
      relay_b_drive  <= next_summary_alarm;
      status_led     <= next_status_led;
      fault_report   <= active;
      irq            <= next_irq;
    end
  end

endmodule : fault_alarm_aggregator

// *** verif/fault_alarm_checker_asserts.sv ***
// Checker for the alarm, mute, relay and indicator outputs
`timescale 1ns/1ps
module fault_alarm_checker
  import fault_alarm_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  rst_n,
  input wire logic                  ext_mute,
  input wire logic                  summary_alarm,
  input wire logic                  changeover_req,
  input wire logic                  output_mute,
  input wire logic                  relay_a_drive,
  input wire logic                  relay_b_drive,
  input wire led_type               status_led,
  input wire logic [NUM_FAULTS-1:0] fault_report
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Masks kept apart from the package so a wrong package table shows up
  property p_alarm_src; summary_alarm == |(fault_report & 19'h3FFFF); endproperty
  a_alarm_src: assert property (p_alarm_src) else $error("alarm differs from sources");
  property p_mute_src; output_mute == |(fault_report & 19'h661FF); endproperty
  a_mute_src: assert property (p_mute_src) else $error("mute differs from sources");
  property p_changeover; changeover_req |-> summary_alarm; endproperty
  a_changeover: assert property (p_changeover) else $error("changeover without alarm");
  property p_relay_pair; relay_a_drive == relay_b_drive; endproperty
  a_relay_pair: assert property (p_relay_pair) else $error("relays split");
  property p_relay_alarm; relay_a_drive == summary_alarm; endproperty
  a_relay_alarm: assert property (p_relay_alarm) else $error("relay not following alarm");
  property p_red; |fault_report |-> status_led == LED_RED; endproperty
  a_red: assert property (p_red) else $error("fault without red");
  property p_green; status_led == LED_GREEN |-> !summary_alarm && fault_report == '0; endproperty
  a_green: assert property (p_green) else $error("green with fault");
  // Pin held long enough must have crossed the synchroniser
  property p_sync; (rst_n && ext_mute) [*6] |-> fault_report[F_EXT_MUTE]; endproperty
  a_sync: assert property (p_sync) else $error("mute pin not reported");
  c_alarm: cover property (summary_alarm);
  c_mute_only: cover property (output_mute && !summary_alarm);
  c_changeover: cover property (changeover_req);
endmodule : fault_alarm_checker

bind fault_alarm_aggregator fault_alarm_checker i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .ext_mute(ext_mute),
  .summary_alarm(summary_alarm), .changeover_req(changeover_req), .output_mute(output_mute),
  .relay_a_drive(relay_a_drive), .relay_b_drive(relay_b_drive), .status_led(status_led),
  .fault_report(fault_report));

// *** verif/fault_far_side_model.sv ***
// Far side model: redundancy switch, fault relays and output mute stage
`timescale 1ns/1ps
module fault_far_side_model (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic changeover_req,
  input  wire logic relay_a_drive,
  input  wire logic relay_b_drive,
  input  wire logic output_mute,
  output logic      standby_on_line,
  output logic      contacts_normal,
  output logic      rf_passed
);
  // Switch latches like a real coax switch; only reset brings the unit back
  always_ff @(posedge sys_clk) begin
    if (!rst_n) standby_on_line <= 1'b0;
    else if (changeover_req) standby_on_line <= 1'b1;
  end
  // Contacts rest only while neither coil is driven
  assign contacts_normal = !relay_a_drive && !relay_b_drive;
  assign rf_passed       = !output_mute;
endmodule : fault_far_side_model

// *** verif/fault_alarm_aggregator_tb_top.sv ***
// Testbench for the fault alarm aggregator
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, g); end end
module fault_alarm_aggregator_tb_top;
  import fault_alarm_pkg::*;
  localparam logic [NUM_FAULTS-1:0] ALARM_EXP = 19'h3FFFF;
  localparam logic [NUM_FAULTS-1:0] MUTE_EXP  = 19'h661FF;
  logic                  sys_clk = 1'b0;
  logic                  rst_n   = 1'b0;
  logic [NUM_FAULTS-1:0] pins    = '0;
  logic [ADDR_W-1:0]     reg_addr = '0;
  logic [31:0]           reg_wdata = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic [31:0]           reg_rdata;
  logic                  summary_alarm, changeover_req, output_mute, relay_a_drive, relay_b_drive, irq;
  led_type               status_led;
  logic [NUM_FAULTS-1:0] fault_report;
  logic                  standby_on_line, contacts_normal, rf_passed;
  int                    fails = 0;
  int                    total_checks = 0;

  always #2.5 sys_clk = ~sys_clk;

  fault_alarm_aggregator i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .psu_5v_fault(pins[0]), .psu_p15v_fault(pins[1]), .psu_n15v_fault(pins[2]), .psu_p36v_fault(pins[3]),
    .thermal_sensor_alarm(pins[4]), .humidity_fault(pins[5]), .general_fault(pins[6]), .ref_100m_fault(pins[7]),
    .coax_switch_fault(pins[8]), .block_fault(pins[9]), .psu_p3v_fault(pins[10]), .dc_feed_fault(pins[11]),
    .psu_p5v_fault(pins[12]), .lo1_fault(pins[13]), .lo2_fault(pins[14]), .int_block_fault(pins[15]),
    .ext_fault(pins[16]), .int_shf_fault(pins[17]), .ext_mute(pins[18]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .summary_alarm(summary_alarm), .changeover_req(changeover_req), .output_mute(output_mute),
    .relay_a_drive(relay_a_drive), .relay_b_drive(relay_b_drive), .status_led(status_led),
    .fault_report(fault_report), .irq(irq));

  fault_far_side_model i_far (.sys_clk(sys_clk), .rst_n(rst_n), .changeover_req(changeover_req),
    .relay_a_drive(relay_a_drive), .relay_b_drive(relay_b_drive), .output_mute(output_mute),
    .standby_on_line(standby_on_line), .contacts_normal(contacts_normal), .rf_passed(rf_passed));
  ////////////////////////////////////////
  // Pin changes need up to five cycles through the synchroniser
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : settle

  // Pins change right after a rising edge, never between edges
  task automatic set_pins(input logic [NUM_FAULTS-1:0] v);
    @(posedge sys_clk);
    pins <= v;
  endtask : set_pins

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd

  task automatic results();
    $display("Checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  ////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    results();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    `CHK("led_idle", LED_GREEN, status_led)
    `CHK("contacts", 1'b1, contacts_normal)
    rd(REG_CONTROL, 32'h0);
    rd(4'hF, 32'h0);
    $display("Test reset done");
    // Each source alone
    for (int i = 0; i < NUM_FAULTS; i++) begin
      set_pins(19'h1 << i);
      settle();
      `CHK("alarm", ALARM_EXP[i], summary_alarm)
      `CHK("mute", MUTE_EXP[i], output_mute)
      `CHK("led", LED_RED, status_led)
      `CHK("report", 19'h1 << i, fault_report)
      `CHK("relay_b", ALARM_EXP[i], relay_b_drive)
      `CHK("contacts_src", !ALARM_EXP[i], contacts_normal)
      rd(REG_FAULT_NOW, 32'h1 << i);
      set_pins('0);
      settle();
    end
    $display("Test sources done");
    // Redundant standby unit
    wr(REG_CONTROL, 32'h3);
    rd(REG_CONTROL, 32'h3);
    settle();
    `CHK("led_amber", LED_AMBER, status_led)
    set_pins(19'h1 << F_EXT_MUTE);
    settle();
    `CHK("led_mute", LED_RED, status_led)
    `CHK("co_mute", 1'b0, changeover_req)
    rd(REG_SUMMARY, 32'h7);
    set_pins(19'h1 << F_EXT_FAULT);
    settle();
    `CHK("co_fault", 1'b1, changeover_req)
    `CHK("standby", 1'b1, standby_on_line)
    set_pins('0);
    wr(REG_CONTROL, 32'h0);
    $display("Test redundancy done");
    // Interrupt raise, mask and clear
    wr(REG_EVT_CLEAR, 32'h1FFFFF);
    wr(REG_EVT_ENABLE, 32'h1 << F_GENERAL);
    rd(REG_EVT_ENABLE, 32'h40);
    settle();
    `CHK("irq_quiet", 1'b0, irq)
    set_pins(19'h1 << F_GENERAL);
    settle();
    `CHK("irq_set", 1'b1, irq)
    rd(REG_EVT_STATUS, 32'h180040);
    wr(REG_EVT_ENABLE, 32'h0);
    settle();
    `CHK("irq_mask", 1'b0, irq)
    wr(REG_EVT_ENABLE, 32'h1 << F_GENERAL);
    set_pins('0);
    settle();
    `CHK("irq_back", 1'b1, irq)
    wr(REG_EVT_CLEAR, 32'h1FFFFF);
    settle();
    `CHK("irq_clr", 1'b0, irq)
    wr(REG_FAULT_NOW, 32'h7);
    rd(REG_FAULT_NOW, 32'h0);
    $display("Test interrupt done");
    // Injected test fault
    wr(REG_FORCE, 32'h1 << F_LO1);
    settle();
    `CHK("force_mute", 1'b0, rf_passed)
    rd(REG_FORCE, 32'h1 << F_LO1);
    wr(REG_FORCE, 32'h0);
    settle();
    `CHK("force_off", 1'b1, rf_passed)
    $display("Test force done");
    // Reset in mid-run clears injected faults and the latched change-over
    wr(REG_FORCE, 32'h1 << F_LO1);
    settle();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("led_rst", LED_OFF, status_led)
    `CHK("mute_rst", 1'b1, rf_passed)
    `CHK("standby_rst", 1'b0, standby_on_line)
    @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    `CHK("led_back", LED_GREEN, status_led)
    rd(REG_FORCE, 32'h0);
    $display("Test reset again done");
    results();
  end
endmodule : fault_alarm_aggregator_tb_top
